// file: hdl/adc_mode_control_sequencer.sv
`timescale 1ns/1ps

module adc_mode_control_sequencer
  import adc_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic [RESULT_BITS-1:0] result_code,
  output logic dout,
  output logic conversion_done_strobe,
  output logic sample_pulse,
  output logic analog_power_on,
  output logic reference_power_on,
  output logic channel_config_reset,
  output method_type conv_method
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  typedef enum {seq_idle, seq_ext_run, seq_acq_wait, seq_iclk_arm, seq_iclk_delay,
                seq_iclk_acq, seq_converting, seq_push} seq_type;

  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_level;
  logic [2:0] pin_prev;

  assign pin_raw = {din, sclk, cs_n};

  // three stages; a level only counts once stages two and three agree
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync1[i] <= PIN_IDLE[i];
        sync2[i] <= PIN_IDLE[i];
        sync3[i] <= PIN_IDLE[i];
        pin_level[i] <= PIN_IDLE[i];
        pin_prev[i] <= PIN_IDLE[i];
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) pin_level[i] <= sync3[i];
        pin_prev[i] <= pin_level[i];
      end
    end
  end

  wire cs_active = ~pin_level[0];
  wire sclk_rise = pin_level[1] & ~pin_prev[1];
  wire sclk_fall = ~pin_level[1] & pin_prev[1];
  wire din_level = pin_level[2];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_type seq;
  power_type power;
  logic rx_active;
  logic [2:0] rx_count;
  logic [5:0] rx_bits;
  logic [4:0] fall_count;
  logic [3:0] wait_count;
  logic [3:0] iclk_div;
  logic [4:0] iclk_count;
  logic ext_read_due;
  logic frame_read;
  logic [RESULT_BITS-1:0] out_shift;
  logic [3:0] out_left;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [RESULT_BITS-1:0] buf_out_data;

  // ----------------------------------------------------------------
  // byte reception and decode
  // ----------------------------------------------------------------
  // bits that may still be pending when a new start bit is allowed
  wire [3:0] start_left_limit = (conv_method == ext_clock) ? EXT_CLK_START_LEFT :
                                (conv_method == ext_acquisition) ? EXT_ACQ_START_LEFT :
                                INT_CLK_START_LEFT;
  wire start_allowed = cs_active & ~rx_active & (seq == seq_idle) &
                       ((out_left == 4'h0) || (out_left <= start_left_limit));
  wire start_bit = sclk_rise & din_level & start_allowed;
  wire rx_last = rx_active & cs_active & sclk_rise & (rx_count == RX_LAST_BIT);
  wire [7:0] rx_byte = {1'b1, rx_bits, din_level};
  wire is_mode_byte = rx_byte[MODE_MARK_BIT] & (rx_byte[2:0] == MODE_LOW_BITS);
  wire [2:0] mode_code = rx_byte[MODE_FIELD_MSB:MODE_FIELD_LSB];
  // bytes without the mode mark start a conversion; marked bytes with nonzero low bits are ignored
  wire is_conv_byte = ~rx_byte[MODE_MARK_BIT];
  wire mode_write = rx_last & is_mode_byte;
  // no conversion while powered down or while the buffer cannot take a word
  wire conv_go = rx_last & is_conv_byte & (power == full_power) & buf_in_ready & (seq == seq_idle);

  // shift in the seven bits after the start bit on rising edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_active <= 1'b0;
      rx_count <= 3'h0;
      rx_bits <= 6'h00;
    end else if (!cs_active || rx_last) begin
      rx_active <= 1'b0;
    end else if (start_bit) begin
      rx_active <= 1'b1;
      rx_count <= 3'h0;
    end else if (rx_active && sclk_rise) begin
      rx_bits <= {rx_bits[4:0], din_level};
      rx_count <= rx_count + 3'h1;
    end
  end

  // falling edges since the start bit, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) fall_count <= 5'h00;
    else if (start_bit) fall_count <= 5'h00;
    else if (sclk_fall && cs_active && fall_count != 5'h1f) fall_count <= fall_count + 5'h01;
  end

  // ----------------------------------------------------------------
  // mode and power
  // ----------------------------------------------------------------
  method_type next_method;
  power_type next_power;
  logic next_cfg_reset;

  // only a decoded mode byte moves method or power; select alone never wakes
  always_comb begin
    next_method = conv_method;
    next_power = power;
    next_cfg_reset = 1'b0;
    if (mode_write) begin
      case (mode_code)
        MODE_EXT_CLOCK: begin
          next_method = ext_clock;
          next_power = full_power;
        end
        MODE_EXT_ACQ: begin
          next_method = ext_acquisition;
          next_power = full_power;
        end
        MODE_INT_CLOCK: begin
          next_method = int_clock;
          next_power = full_power;
        end
        MODE_RESET: begin
          next_method = ext_clock;
          next_power = full_power;
          next_cfg_reset = 1'b1;
        end
        MODE_PARTIAL_DOWN: next_power = partial_down;
        MODE_FULL_DOWN: next_power = full_down;
        default: next_power = power;
      endcase
    end
  end

  // power-on state is full power in external clock mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_method <= ext_clock;
      power <= full_power;
      analog_power_on <= 1'b1;
      reference_power_on <= 1'b1;
      channel_config_reset <= 1'b0;
    end else begin
      conv_method <= next_method;
      power <= next_power;
      analog_power_on <= (next_power == full_power);
      reference_power_on <= (next_power != full_down);  // partial keeps the reference
      channel_config_reset <= next_cfg_reset;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  wire iclk_tick = (iclk_div == 4'(ICLK_DIV_CYCLES - 1));
  wire iclk_running = (seq == seq_iclk_acq) || (seq == seq_converting);
  wire ext_sample = sclk_fall & (fall_count == EXT_CLK_SAMPLE_FALL - 5'h01);
  wire acq_sample = sclk_fall & (fall_count == EXT_ACQ_SAMPLE_FALL - 5'h01);
  wire iclk_trigger = sclk_fall & (fall_count == ICLK_TRIGGER_FALL - 5'h01);
  wire iclk_sample = iclk_tick & (iclk_count == ICLK_SAMPLE_EDGE - 5'h01);
  assign buf_in_valid = (seq == seq_push);

  // internal clock divider, free only while the internal clock is on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) iclk_div <= 4'h0;
    else if (!iclk_running || iclk_tick) iclk_div <= 4'h0;
    else iclk_div <= iclk_div + 4'h1;
  end

  // select going high before the sample abandons a serially clocked request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq <= seq_idle;
      wait_count <= 4'h0;
      iclk_count <= 5'h00;
      sample_pulse <= 1'b0;
    end else begin
      sample_pulse <= 1'b0;
      case (seq)
        seq_idle: begin
          if (conv_go) begin
            case (conv_method)
              ext_clock: seq <= seq_ext_run;
              ext_acquisition: seq <= seq_acq_wait;
              int_clock: seq <= seq_iclk_arm;
              default: seq <= seq_idle;
            endcase
          end
        end
        seq_ext_run: begin
          if (!cs_active) seq <= seq_idle;
          else if (ext_sample) begin
            sample_pulse <= 1'b1;
            seq <= seq_push;
          end
        end
        seq_acq_wait: begin
          if (!cs_active) seq <= seq_idle;
          else if (acq_sample) begin
            sample_pulse <= 1'b1;
            iclk_count <= 5'h00;
            seq <= seq_converting;
          end
        end
        seq_iclk_arm: begin
          if (!cs_active) seq <= seq_idle;
          else if (iclk_trigger) begin
            wait_count <= 4'(ICLK_START_CYCLES - 1);
            seq <= seq_iclk_delay;
          end
        end
        seq_iclk_delay: begin
          if (wait_count == 4'h0) begin
            iclk_count <= 5'h00;
            seq <= seq_iclk_acq;
          end else wait_count <= wait_count - 4'h1;
        end
        seq_iclk_acq: begin
          if (iclk_sample) begin
            sample_pulse <= 1'b1;
            iclk_count <= 5'h00;
            seq <= seq_converting;
          end else if (iclk_tick) iclk_count <= iclk_count + 5'h01;
        end
        seq_converting: begin
          if (iclk_tick) begin
            if (iclk_count == CONV_ICLK_COUNT - 5'h01) seq <= seq_push;
            else iclk_count <= iclk_count + 5'h01;
          end
        end
        seq_push: begin
          if (buf_in_ready) seq <= seq_idle;  // a full buffer stalls here
        end
        default: seq <= seq_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // done strobe
  // ----------------------------------------------------------------
  wire push_done = buf_in_valid & buf_in_ready;
  wire strobe_set = push_done & (conv_method != ext_clock);

  // the set wins over the start-bit clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) conversion_done_strobe <= 1'b0;
    else if (strobe_set) conversion_done_strobe <= 1'b1;
    else if (start_bit || next_method == ext_clock) conversion_done_strobe <= 1'b0;
  end

  // ----------------------------------------------------------------
  // result buffer and output shifter
  // ----------------------------------------------------------------
  wire ext_pop = (conv_method == ext_clock) & ext_read_due &
                 (fall_count == EXT_CLK_FIRST_OUT_FALL - 5'h01);
  wire read_pop = (conv_method != ext_clock) & ~rx_active & (seq == seq_idle) & ~frame_read;
  wire shifter_load = sclk_fall & cs_active & (out_left == 4'h0) & buf_out_valid & (ext_pop | read_pop);

  two_entry_buffer #(
    .WIDTH(RESULT_BITS)
  ) u_result_buffer (
    .clk(clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(result_code),
    .out_valid(buf_out_valid),
    .out_ready(shifter_load),
    .out_data(buf_out_data)
  );

  // in mode 0 the word is read in the same frame as its request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ext_read_due <= 1'b0;
    else if (push_done && conv_method == ext_clock) ext_read_due <= 1'b1;
    else if (shifter_load || !cs_active) ext_read_due <= 1'b0;
  end

  // one word per select period outside mode 0; a second load near the frame end would be dropped on select rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) frame_read <= 1'b0;
    else if (!cs_active) frame_read <= 1'b0;
    else if (shifter_load) frame_read <= 1'b1;
  end

  // msb first, new bit on each falling serial clock edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
      out_shift <= '0;
      out_left <= 4'h0;
    end else if (shifter_load) begin
      dout <= buf_out_data[RESULT_BITS-1];
      out_shift <= {buf_out_data[RESULT_BITS-2:0], 1'b0};
      out_left <= RESULT_LAST_INDEX;
    end else if (sclk_fall && cs_active && out_left != 4'h0) begin
      dout <= out_shift[RESULT_BITS-1];
      out_shift <= {out_shift[RESULT_BITS-2:0], 1'b0};
      out_left <= out_left - 4'h1;
    end else if (!cs_active) begin
      dout <= 1'b0;  // a partly read word is dropped when select rises
      out_left <= 4'h0;
    end
  end

endmodule

// file: hdl/adc_mode_pkg.sv
package adc_mode_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_FREQ_KHZ = 10000;
  // internal conversion clock, about 4.5 MHz
  localparam int ICLK_FREQ_KHZ = 4500;
  // longest period rounds down, never below one cycle
  localparam int ICLK_DIV_RAW = CLK_FREQ_KHZ / ICLK_FREQ_KHZ;
  localparam int ICLK_DIV_CYCLES = (ICLK_DIV_RAW < 1) ? 1 : ICLK_DIV_RAW;
  // internal clock starts 100 ns to 400 ns after the eighth falling edge
  localparam int ICLK_START_MIN_NS = 100;
  localparam int ICLK_START_RAW = (ICLK_START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ICLK_START_CYCLES = (ICLK_START_RAW < 1) ? 1 : ICLK_START_RAW;
  // internal clock falling edge that samples the input
  localparam logic [4:0] ICLK_SAMPLE_EDGE = 5'h0b;
  // internal clocks spent converting after the sample
  localparam logic [4:0] CONV_ICLK_COUNT = 5'h10;

  // ----------------------------------------------------------------
  // serial clock edge positions, counted from the start bit
  // ----------------------------------------------------------------
  localparam logic [4:0] EXT_CLK_SAMPLE_FALL = 5'h0e;
  localparam logic [4:0] EXT_ACQ_SAMPLE_FALL = 5'h10;
  localparam logic [4:0] ICLK_TRIGGER_FALL = 5'h08;
  localparam logic [4:0] EXT_CLK_FIRST_OUT_FALL = 5'h10;
  localparam logic [2:0] RX_LAST_BIT = 3'h6;

  // ----------------------------------------------------------------
  // operating mode byte layout
  // ----------------------------------------------------------------
  localparam int MODE_START_BIT = 7;
  localparam int MODE_FIELD_MSB = 6;
  localparam int MODE_FIELD_LSB = 4;
  localparam int MODE_MARK_BIT = 3;
  localparam logic [2:0] MODE_LOW_BITS = 3'h0;
  localparam logic [2:0] MODE_EXT_CLOCK = 3'h0;
  localparam logic [2:0] MODE_EXT_ACQ = 3'h1;
  localparam logic [2:0] MODE_INT_CLOCK = 3'h2;
  localparam logic [2:0] MODE_RESET = 3'h4;
  localparam logic [2:0] MODE_PARTIAL_DOWN = 3'h6;
  localparam logic [2:0] MODE_FULL_DOWN = 3'h7;

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 14;
  localparam logic [3:0] RESULT_LAST_INDEX = 4'hd;
  // bits still to leave when a new start bit may be taken, per method
  localparam logic [3:0] EXT_CLK_START_LEFT = 4'h1;
  localparam logic [3:0] EXT_ACQ_START_LEFT = 4'h5;
  localparam logic [3:0] INT_CLK_START_LEFT = 4'h2;
  // pin reset levels, order {din, sclk, cs_n}
  localparam logic [2:0] PIN_IDLE = 3'h1;

  typedef enum logic [1:0] {ext_clock, ext_acquisition, int_clock} method_type;
  typedef enum logic [1:0] {full_power, partial_down, full_down} power_type;

endpackage

// file: hdl/two_entry_buffer.sv
`timescale 1ns/1ps

// two-word buffer between the converter and the output shifter
module two_entry_buffer
  import adc_mode_pkg::*;
#(
  parameter int WIDTH = RESULT_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] store [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // full and empty come straight from the fill count
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = store[rd_ptr];

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end

  // storage needs no reset, it is only read while counted valid
  always_ff @(posedge clk) begin
    if (push) store[wr_ptr] <= in_data;
  end

endmodule

// file: tb/adc_mode_props.sv
`timescale 1ns/1ps

module adc_mode_props
  import adc_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic conversion_done_strobe,
  input wire logic sample_pulse,
  input wire logic analog_power_on,
  input wire logic reference_power_on,
  input wire logic channel_config_reset,
  input wire method_type conv_method
);
  logic [7:0] since_cs;
  wire logic [7:0] next_since_cs;

  // clocks since select was last low; saturates so long idle stays idle
  assign next_since_cs = !cs_n ? 8'h00 : (since_cs == 8'hff) ? since_cs : since_cs + 8'h01;

  // counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_cs <= 8'hff;
    end else begin
      since_cs <= next_since_cs;
    end
  end

  // --------------------
  // properties
  // --------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_strobe_ext_low: assert property (
    conv_method == ext_clock && $past(conv_method) == ext_clock |-> !conversion_done_strobe)
    else $error("done strobe high in external clock method");
  a_strobe_rise_mode: assert property (
    $rose(conversion_done_strobe) |-> conv_method != ext_clock)
    else $error("done strobe rose in external clock method");
  a_strobe_holds_idle: assert property (
    conversion_done_strobe && since_cs > 8'h10 |=> conversion_done_strobe)
    else $error("done strobe dropped without a frame");
  a_strobe_fall_frame: assert property (
    $fell(conversion_done_strobe) |-> since_cs <= 8'h10)
    else $error("done strobe fell outside a frame");
  a_cfg_gives_defaults: assert property (
    channel_config_reset |-> ##[0:2] (analog_power_on && reference_power_on && conv_method == ext_clock))
    else $error("reset code did not restore defaults");
  a_power_nesting: assert property (
    analog_power_on |-> reference_power_on)
    else $error("analog powered while reference is down");
  a_power_needs_byte: assert property (
    $changed(analog_power_on) || $changed(reference_power_on) |-> since_cs <= 8'h10)
    else $error("power state moved without a frame");
  a_method_needs_byte: assert property (
    $changed(conv_method) |-> since_cs <= 8'h10)
    else $error("method moved without a frame");
  a_ext_sample_framed: assert property (
    sample_pulse && conv_method == ext_clock |-> !cs_n)
    else $error("external clock sample outside a frame");
  a_dout_idle_low: assert property (
    since_cs > 8'h05 |-> !dout)
    else $error("serial output driven while deselected");

  c_strobe_up: cover property ($rose(conversion_done_strobe));
  c_int_sample: cover property (sample_pulse && conv_method == int_clock);
  c_cfg_pulse: cover property (channel_config_reset);
endmodule

bind adc_mode_control_sequencer adc_mode_props u_props (
  .clk(clk), .rst(rst), .cs_n(cs_n), .dout(dout),
  .conversion_done_strobe(conversion_done_strobe), .sample_pulse(sample_pulse),
  .analog_power_on(analog_power_on), .reference_power_on(reference_power_on),
  .channel_config_reset(channel_config_reset), .conv_method(conv_method)
);

// file: tb/host_port_model.sv
`timescale 1ns/1ps

module host_port_model (
  input wire logic clk,
  input wire logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  logic din_q;
  logic idle_pat = 1'b0;

  // released data line toggles so a stale level never passes for data
  always @(negedge clk) begin
    idle_pat <= ~idle_pat;
  end
  assign din = cs_n ? idle_pat : din_q;

  // serial clock stands still low outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din_q = 1'b0;
  end

  // --------------------
  // one framed transfer: byte first, then n-8 zero bits, dout captured per cycle
  // --------------------
  task automatic frame(input logic [7:0] b, input int n, output logic [15:0] rd);
    int k;
    rd = 16'h0000;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (k = 0; k < n; k++) begin
      din_q = (k < 8) ? b[7 - k] : 1'b0;
      sclk = 1'b0;
      repeat (4) @(negedge clk);  // fixed half period
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rd = {rd[14:0], dout};
    end
    sclk = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;  // only after the last falling edge
    din_q = 1'b0;
    repeat (6) @(negedge clk);  // select must be seen high between frames
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
  import adc_mode_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [RESULT_BITS-1:0] result_code = 14'h0000;
  logic cs_n, sclk, din, dout, conversion_done_strobe, sample_pulse;
  logic analog_power_on, reference_power_on, channel_config_reset;
  method_type conv_method;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 9;
  int m_method = 0;
  int m_power = 0;
  int m_cfg = 0;
  int m_samp = 0;
  int cfg_seen = 0;
  int samp_seen = 0;
  int i;
  int exp_q[$];
  int codes[8] = '{6, 3, 5, 7, 6, 2, 4, 1};
  logic [15:0] rd;

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  // pulse counters, read mid-cycle so the launching edge never races the count
  always @(negedge clk) begin
    if (channel_config_reset === 1'b1) cfg_seen++;
    if (sample_pulse === 1'b1) samp_seen++;
  end

  adc_mode_control_sequencer u_adc_mode_control_sequencer (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .result_code(result_code),
    .dout(dout), .conversion_done_strobe(conversion_done_strobe), .sample_pulse(sample_pulse),
    .analog_power_on(analog_power_on), .reference_power_on(reference_power_on),
    .channel_config_reset(channel_config_reset), .conv_method(conv_method)
  );

  host_port_model u_host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));

  // --------------------
  // closing and helpers
  // --------------------
  task automatic report_and_stop;
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // mode byte, then a two-bit frame of zeros with no start bit that must change nothing
  task automatic mode_byte(input int code);
    u_host.frame({1'b1, code[2:0], 4'h8}, 8, rd);
    case (code)
      0, 1, 2: begin m_method = code; m_power = 0; end
      4: begin m_method = 0; m_power = 0; m_cfg++; end
      6: m_power = 1;
      7: m_power = 2;
      default: ;
    endcase
    u_host.frame(8'h00, 2, rd);
    repeat (6) @(negedge clk);
    `CHECK("method", 2'(m_method), conv_method)
    `CHECK("analog", m_power == 0, analog_power_on)
    `CHECK("reference", m_power != 2, reference_power_on)
    `CHECK("cfg_pulses", m_cfg, cfg_seen)
    `CHECK("strobe_low", 1'b0, conversion_done_strobe)
  endtask

  // conversion-start byte with random channel bits and a fresh core value
  task automatic convert(input int n);
    result_code = 14'($random(seed));
    exp_q.push_back(result_code);
    m_samp++;
    u_host.frame(8'h80 | (8'($random(seed)) & 8'h70), n, rd);
  endtask

  task automatic wait_strobe;
    int t;
    for (t = 0; t < 300 && conversion_done_strobe !== 1'b1; t++) begin
      @(negedge clk);
    end
    `CHECK("strobe_up", 1'b1, conversion_done_strobe)
    if (conversion_done_strobe !== 1'b1) begin
      report_and_stop;
    end
  endtask

  task automatic check_word(input logic [13:0] got);
    logic [13:0] e;
    e = 14'(exp_q.pop_front());
    `CHECK("word", e, got)
    `CHECK("samples", m_samp, samp_seen)
  endtask

  // --------------------
  // main sequence
  // --------------------
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    `CHECK("method", ext_clock, conv_method)
    `CHECK("analog", 1'b1, analog_power_on)
    for (i = 0; i < 14; i++) begin
      mode_byte(i < 8 ? codes[i] : $random(seed) & 7);
    end
    // core model stands for an outside reference, so no settling wait
    mode_byte(0);
    repeat (3) begin
      convert(30);
      check_word(rd[13:0]);
      `CHECK("strobe_ext", 1'b0, conversion_done_strobe)
    end
    mode_byte(1);
    convert(16);
    wait_strobe;
    u_host.frame(8'h00, 16, rd);
    check_word(rd[14:1]);
    mode_byte(2);
    convert(8);
    wait_strobe;
    convert(8);
    `CHECK("strobe_cleared", 1'b0, conversion_done_strobe)
    wait_strobe;
    repeat (2) begin
      u_host.frame(8'h00, 16, rd);
      check_word(rd[14:1]);
    end
    mode_byte(4);
    report_and_stop;
  end
endmodule
